// ===== sfr_space_decoder_regs.svh
`ifndef SFR_SPACE_DECODER_REGS_SVH
`define SFR_SPACE_DECODER_REGS_SVH

// ****************************************************************
// Address range of the peripheral register space.
// ****************************************************************
`define SPACE_FIRST_ADDR          8'h80
`define SPACE_LAST_ADDR           8'hff

// ****************************************************************
// Low-nibble codes that mark bit-addressable locations.
// ****************************************************************
`define BIT_NIBBLE_A              4'h0
`define BIT_NIBBLE_B              4'h8

// ****************************************************************
// Register offsets.
// ****************************************************************
`define PORT0_LATCH_ADDR          8'h80
`define DATA_POINTER_LOW_ADDR     8'h82
`define DATA_POINTER_HIGH_ADDR    8'h83
`define POWER_CONTROL_ADDR        8'h87
`define CLOCK_CONTROL_ADDR        8'h8e
`define PROGRAM_STORE_RW_CTL_ADDR 8'h8f
`define PORT1_LATCH_ADDR          8'h90
`define TOUCH_THRESHOLD_LOW_ADDR  8'h96
`define TOUCH_THRESHOLD_HIGH_ADDR 8'h97
`define COMPARATOR_CONTROL_ADDR   8'h9b
`define TOUCH_MUX_SELECT_ADDR     8'h9c
`define COMPARATOR_MODE_ADDR      8'h9d
`define TOUCH_CONFIGURATION_ADDR  8'h9e
`define COMPARATOR_MUX_SEL_ADDR   8'h9f
`define PORT2_LATCH_ADDR          8'ha0
`define PORT0_OUTPUT_MODE_ADDR    8'ha4
`define PORT1_OUTPUT_MODE_ADDR    8'ha5
`define PORT2_OUTPUT_MODE_ADDR    8'ha6
`define INTERRUPT_ENABLE_ADDR     8'ha8
`define CLOCK_SOURCE_SELECT_ADDR  8'ha9
`define TOUCH_RESULT_LOW_ADDR     8'hab
`define TOUCH_RESULT_HIGH_ADDR    8'hac
`define VARIANT_ID_BYTE_ADDR      8'had
`define TOUCH_CONTROL_ADDR        8'hb0
`define EXTERNAL_OSC_CONTROL_ADDR 8'hb1
`define INTERNAL_OSC_CONTROL_ADDR 8'hb2
`define INTERNAL_OSC_TRIM_ADDR    8'hb3
`define FAMILY_ID_BYTE_ADDR       8'hb5
`define SILICON_REVISION_ADDR     8'hb6
`define FLASH_LOCK_KEY_ADDR       8'hb7
`define INTERRUPT_PRIORITY_ADDR   8'hb8
`define TOUCH_SCAN_FIRST_ADDR     8'hb9
`define TOUCH_SCAN_LAST_ADDR      8'hba
`define CONVERTER_CHAN_SEL_ADDR   8'hbb
`define CONVERTER_CONFIG_ADDR     8'hbc
`define CONVERTER_RESULT_LOW_ADDR 8'hbd
`define CONVERTER_RESULT_HIGH_ADDR 8'hbe
`define WINDOW_UPPER_LOW_ADDR     8'hc3
`define WINDOW_UPPER_HIGH_ADDR    8'hc4
`define WINDOW_LOWER_LOW_ADDR     8'hc5
`define WINDOW_LOWER_HIGH_ADDR    8'hc6
`define REGULATOR_CONTROL_ADDR    8'hc9
`define CHECKSUM_CONTROL_ADDR     8'hce
`define CHECKSUM_BIT_REVERSE_ADDR 8'hcf
`define PROGRAM_STATUS_WORD_ADDR  8'hd0
`define VOLTAGE_REF_CONTROL_ADDR  8'hd1
`define CHECKSUM_AUTO_CTL_ADDR    8'hd2
`define CHECKSUM_SECTOR_CNT_ADDR  8'hd3

// ****************************************************************
// Reset values of the writable registers and of unread data.
// ****************************************************************
`define REG_RESET_VALUE           8'h00
`define RESERVED_READ_VALUE       8'h00

`endif

// ===== sfr_space_pkg.sv
// ****************************************************************
// Types shared by the register space decoder.
// ****************************************************************
package sfr_space_pkg;

    // One access as the core presents it.
    typedef struct packed {
        logic [7:0] addr;    // Byte address of the access.
        logic       direct;  // High for direct addressing, low for indirect.
        logic       rd;      // Read strobe.
        logic       wr;      // Write strobe.
        logic       bit_op;  // High for a single-bit operation.
        logic [2:0] bit_pos; // Bit position for a single-bit operation.
        logic [7:0] wdata;   // Byte write data.
        logic       wbit;    // Bit write data.
    } core_req_t;

    // The answer to one access.
    typedef struct packed {
        logic [7:0] rdata;       // Byte read data.
        logic       rbit;        // Selected bit of a bit read.
        logic       valid;       // One-cycle pulse marking the answer.
        logic       reserved;    // Access hit an unoccupied location.
        logic       bit_refused; // Bit operation on a byte-only location.
    } core_rsp_t;

    // Destination chosen for an access, one-hot.
    typedef enum logic [2:0] {
        ROUTE_IDLE = 3'b001,
        ROUTE_REGS = 3'b010,
        ROUTE_RAM  = 3'b100
    } route_t;

endpackage : sfr_space_pkg

// ===== sfr_space_decoder.sv
// Summary of operation
// RULE_01: Registers occupy direct addresses 0x80 through 0xFF.
// RULE_02: Direct access above 0x7F goes to registers.
// RULE_03: Low nibble 0 or 8 allows bit access.
// RULE_04: Other addresses allow whole-byte access only.
// RULE_05: Software avoids unoccupied, reserved register addresses.
// RULE_06: Read-only revision byte at 0xB6, revision-dependent.
// RULE_07: Indirect access above 0x7F reaches upper RAM.
// RULE_08: Byte registers, reads answer promptly without side effect.
`timescale 1ns/1ps
`include "sfr_space_decoder_regs.svh"

module sfr_space_decoder
    import sfr_space_pkg::*;
#(
    parameter int         DATA_W        = 8,     // Register width.
    parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] FAMILY_CODE   = 8'h3c, // Arbitrary value.
    parameter logic [7:0] VARIANT_CODE  = 8'h71  // Arbitrary value.
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire core_req_t         req,
    output core_rsp_t              rsp,
    output route_t                 route,
    output logic                   ram_sel,
    output logic [127:0][7:0]      reg_image
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************

    // The space is byte wide; any other width breaks the bit lanes.
    if (DATA_W != 8) begin : g_width_check
        $error("sfr_space_decoder: DATA_W must be 8.");
    end

    // ****************************************************************
    // Decode helpers.
    // ****************************************************************

    // Reports whether an address holds a writable register.
    function automatic logic is_writable(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            `PORT0_LATCH_ADDR,          `DATA_POINTER_LOW_ADDR,
            `DATA_POINTER_HIGH_ADDR,    `POWER_CONTROL_ADDR,
            `CLOCK_CONTROL_ADDR,        `PROGRAM_STORE_RW_CTL_ADDR,
            `PORT1_LATCH_ADDR,          `TOUCH_THRESHOLD_LOW_ADDR,
            `TOUCH_THRESHOLD_HIGH_ADDR, `COMPARATOR_CONTROL_ADDR,
            `TOUCH_MUX_SELECT_ADDR,     `COMPARATOR_MODE_ADDR,
            `TOUCH_CONFIGURATION_ADDR,  `COMPARATOR_MUX_SEL_ADDR,
            `PORT2_LATCH_ADDR,          `PORT0_OUTPUT_MODE_ADDR,
            `PORT1_OUTPUT_MODE_ADDR,    `PORT2_OUTPUT_MODE_ADDR,
            `INTERRUPT_ENABLE_ADDR,     `CLOCK_SOURCE_SELECT_ADDR,
            `TOUCH_RESULT_LOW_ADDR,     `TOUCH_RESULT_HIGH_ADDR,
            `TOUCH_CONTROL_ADDR,        `EXTERNAL_OSC_CONTROL_ADDR,
            `INTERNAL_OSC_CONTROL_ADDR, `INTERNAL_OSC_TRIM_ADDR,
            `FLASH_LOCK_KEY_ADDR,       `INTERRUPT_PRIORITY_ADDR,
            `TOUCH_SCAN_FIRST_ADDR,     `TOUCH_SCAN_LAST_ADDR,
            `CONVERTER_CHAN_SEL_ADDR,   `CONVERTER_CONFIG_ADDR,
            `CONVERTER_RESULT_LOW_ADDR, `CONVERTER_RESULT_HIGH_ADDR,
            `WINDOW_UPPER_LOW_ADDR,     `WINDOW_UPPER_HIGH_ADDR,
            `WINDOW_LOWER_LOW_ADDR,     `WINDOW_LOWER_HIGH_ADDR,
            `REGULATOR_CONTROL_ADDR,    `CHECKSUM_CONTROL_ADDR,
            `CHECKSUM_BIT_REVERSE_ADDR, `PROGRAM_STATUS_WORD_ADDR,
            `VOLTAGE_REF_CONTROL_ADDR,  `CHECKSUM_AUTO_CTL_ADDR,
            `CHECKSUM_SECTOR_CNT_ADDR: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : is_writable

    // Reports whether an address holds a read-only identity byte.
    function automatic logic is_ident(input logic [7:0] a);
        return (a == `VARIANT_ID_BYTE_ADDR) || (a == `FAMILY_ID_BYTE_ADDR) ||
               (a == `SILICON_REVISION_ADDR);
    endfunction : is_ident

    // ****************************************************************
    // Access classification.
    // ****************************************************************

    logic       in_space;     // Address lies in the upper half.
    logic       regs_hit;     // Direct access into the register space.
    logic       any_access;   // A read or a write is requested.
    logic       occupied;     // Address holds some register.
    logic       writable;     // Address holds a writable register.
    logic       bit_capable;  // Address allows bit operations.
    logic       bit_bad;      // Bit operation on a byte-only register.
    logic [6:0] index;        // Storage index within the space.
    logic [7:0] cur_byte;     // Current content at the address.

    // The space runs from its first to its last address inclusive.
    assign in_space = (req.addr >= `SPACE_FIRST_ADDR) &&
                      (req.addr <= `SPACE_LAST_ADDR); // see RULE_01
    assign any_access = req.rd | req.wr;
    // Only the direct mode reaches the registers; indirect goes to RAM.
    assign regs_hit = any_access & req.direct & in_space; // see RULE_02
    assign index    = req.addr[6:0];
    assign writable = is_writable(req.addr);
    assign occupied = writable | is_ident(req.addr);
    // Bit access is legal only where the low nibble is 0 or 8.
    assign bit_capable = (req.addr[3:0] == `BIT_NIBBLE_A) ||
                         (req.addr[3:0] == `BIT_NIBBLE_B); // see RULE_03
    // A bit operation anywhere else is refused and changes nothing.
    assign bit_bad = req.bit_op & ~bit_capable; // see RULE_04

    // ****************************************************************
    // Routing.
    // ****************************************************************

    // Steers each access to the registers or to data RAM.
    always_comb begin
        if (!any_access) begin
            route = ROUTE_IDLE;
        end else if (regs_hit) begin
            route = ROUTE_REGS; // see RULE_02
        end else begin
            // Indirect accesses above 0x7F share addresses with the
            // registers but must reach the separate upper RAM.
            route = ROUTE_RAM; // see RULE_07
        end
    end

    // The RAM select is a handshake output and may be combinational.
    assign ram_sel = (route == ROUTE_RAM); // see RULE_07

    // ****************************************************************
    // Register storage.
    // ****************************************************************

    logic [7:0] store_r [128]; // One byte per location of the space.

    // Content of the addressed location, identity bytes included.
    always_comb begin
        if (req.addr == `SILICON_REVISION_ADDR) begin
            cur_byte = REVISION_CODE; // see RULE_06
        end else if (req.addr == `FAMILY_ID_BYTE_ADDR) begin
            cur_byte = FAMILY_CODE;
        end else if (req.addr == `VARIANT_ID_BYTE_ADDR) begin
            cur_byte = VARIANT_CODE;
        end else if (writable) begin
            cur_byte = store_r[index];
        end else begin
            cur_byte = `RESERVED_READ_VALUE;
        end
    end

    // Writes land only on writable, occupied locations. Identity bytes
    // ignore writes, and reserved locations keep no state, so a stray
    // write there is harmless rather than undefined.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < 128; i++) begin
                store_r[i] <= `REG_RESET_VALUE;
            end
        end else if (regs_hit && req.wr && writable && !bit_bad) begin
            if (req.bit_op) begin
                store_r[index][req.bit_pos] <= req.wbit; // see RULE_03
            end else begin
                store_r[index] <= req.wdata; // see RULE_08
            end
        end
    end

    // The peripherals see the writable register contents straight from flops, the identity bytes as constants.
    always_comb begin
        for (int i = 0; i < 128; i++) begin
            reg_image[i] = store_r[i];
        end
        reg_image[`SILICON_REVISION_ADDR - 8'h80] = REVISION_CODE; // see RULE_06
        reg_image[`FAMILY_ID_BYTE_ADDR - 8'h80]   = FAMILY_CODE;
        reg_image[`VARIANT_ID_BYTE_ADDR - 8'h80]  = VARIANT_CODE;
    end

    // ****************************************************************
    // Answer path.
    // ****************************************************************

    // Every register access is answered one cycle later. A read leaves
    // the content untouched; reserved locations read as a fixed value
    // and raise a flag, since software is expected to stay away.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.valid       <= regs_hit; // see RULE_08
            rsp.reserved    <= regs_hit & ~occupied; // see RULE_05
            rsp.bit_refused <= regs_hit & bit_bad; // see RULE_04
            if (regs_hit && req.rd && !bit_bad) begin
                rsp.rdata <= cur_byte; // see RULE_08
                rsp.rbit  <= cur_byte[req.bit_pos];
            end else begin
                rsp.rdata <= `RESERVED_READ_VALUE;
                rsp.rbit  <= 1'b0;
            end
        end
    end

endmodule : sfr_space_decoder

// ===== sfr_space_decoder_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Checker on the ports of the register space decoder.
// ****************************************************************
module sfr_space_decoder_sva
    import sfr_space_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a // Arbitrary value.
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire core_req_t         req,
    input wire core_rsp_t         rsp,
    input wire route_t            route,
    input wire logic              ram_sel,
    input wire logic [127:0][7:0] reg_image
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A direct access to the upper half is a register access.
    wire logic acc = (req.rd | req.wr) & req.direct & req.addr[7];
    // Low nibble zero or eight means the low three bits are zero.
    wire logic nib_ok = (req.addr[2:0] == 3'h0);
    property p_regs; acc |-> route == ROUTE_REGS && !ram_sel; endproperty
    property p_ram; (req.rd | req.wr) && !acc |-> route == ROUTE_RAM && ram_sel; endproperty
    property p_ans; acc |=> rsp.valid; endproperty
    property p_no_ans; (req.rd | req.wr) && !acc |=> !rsp.valid; endproperty
    property p_bit_ok; acc && req.bit_op && nib_ok |=> !rsp.bit_refused; endproperty
    property p_bit_no; acc && req.bit_op && !nib_ok |=> rsp.bit_refused && rsp.rdata == 8'h00;
    endproperty
    property p_rev; reg_image[7'h36] == REVISION_CODE; endproperty
    property p_rev_rd; acc && req.rd && req.addr == 8'hb6 |=> rsp.rdata == REVISION_CODE;
    endproperty
    property p_store; acc && req.wr && !req.bit_op && req.addr == 8'h90
        |=> reg_image[7'h10] == $past(req.wdata); endproperty
    a_regs: assert property (p_regs)
        else $error("direct upper access not routed to registers");
    a_ram: assert property (p_ram)
        else $error("memory access not routed to ram");
    a_ans: assert property (p_ans)
        else $error("register access without answer");
    a_no_ans: assert property (p_no_ans)
        else $error("answer for a ram access");
    a_bit_ok: assert property (p_bit_ok)
        else $error("bit access refused at bit location");
    a_bit_no: assert property (p_bit_no)
        else $error("bit access accepted at byte-only location");
    a_rev: assert property (p_rev)
        else $error("revision byte changed");
    a_rev_rd: assert property (p_rev_rd)
        else $error("revision byte read wrong");
    a_store: assert property (p_store)
        else $error("byte write not stored");
    // The main scenarios of the bench.
    c_bitwr: cover property (acc && req.wr && req.bit_op && nib_ok);
    c_refused: cover property (rsp.bit_refused);
    c_indirect: cover property (req.rd && !req.direct && req.addr[7]);
    c_reserved: cover property (rsp.reserved);
endmodule : sfr_space_decoder_sva

bind sfr_space_decoder sfr_space_decoder_sva #(.REVISION_CODE(REVISION_CODE))
    sfr_space_decoder_sva_inst (.core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp),
    .route(route), .ram_sel(ram_sel), .reg_image(reg_image));

// ===== core_access_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Core model issuing one access at a time.
// ****************************************************************
module core_access_model
    import sfr_space_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      ram_sel,
    output core_req_t      req,
    input  wire core_rsp_t rsp
);
    // The core sits idle until the bench hands it an access.
    initial begin
        req = '0;
    end
    // Reserved places are reached only when a scenario asks for one.
    task automatic access(input core_req_t q, output core_rsp_t r, output logic sel);
        @(posedge core_clk);
        #1 req = q;
        #1 sel = ram_sel;
        @(posedge core_clk);
        // Released address and data lines show the inverse of the last value and the strobes drop, so nothing stale looks valid.
        #1 req = '{addr: ~q.addr, wdata: ~q.wdata, default: 1'b0};
        r = rsp;
    endtask : access
endmodule : core_access_model

// ===== sfr_space_decoder_tb.sv
`timescale 1ns/1ps
module sfr_space_decoder_tb
    import sfr_space_pkg::*;
;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary value, handed to the design.
    logic              core_clk;
    logic              rst;
    core_req_t         req;
    core_rsp_t         rsp;
    route_t            route;
    logic              ram_sel;
    logic [127:0][7:0] reg_image;
    core_rsp_t         r;
    logic              sel;
    int                err_total;
    int                n_tests;
    int                cycles;
    logic [7:0]        tbl [4] = '{8'h80, 8'h8f, 8'ha8, 8'hd3}; // Edge registers.
    sfr_space_decoder #(.REVISION_CODE(REV)) sfr_space_decoder_inst (.core_clk(core_clk),
        .rst(rst), .req(req), .rsp(rsp), .route(route), .ram_sel(ram_sel),
        .reg_image(reg_image));
    core_access_model core_access_model_inst (.core_clk(core_clk), .ram_sel(ram_sel),
        .req(req), .rsp(rsp));
    // 20 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic core_req_t mk(input logic [7:0] a, input logic d, input logic rd,
        input logic wr, input logic bo, input logic [2:0] bp, input logic [7:0] wd);
        mk = {a, d, rd, wr, bo, bp, wd, 1'b1};
    endfunction : mk
    task automatic go(input core_req_t q);
        core_access_model_inst.access(q, r, sel);
    endtask : go
    // Reset contents and the read-only revision byte.
    task automatic t_after_reset();
        go(mk(8'h90, 1, 1, 0, 0, 0, 8'h00));
        check(r.rdata, 8'h00);
        go(mk(8'hb6, 1, 0, 1, 0, 0, 8'hff));
        go(mk(8'hb6, 1, 1, 0, 0, 0, 8'h00));
        check(r.rdata, REV);
    endtask : t_after_reset
    // Byte writes at the edges of the space, read back, then a reserved top address.
    task automatic t_bytes();
        foreach (tbl[i]) go(mk(tbl[i], 1, 0, 1, 0, 0, tbl[i] ^ 8'h5c));
        foreach (tbl[i]) begin
            go(mk(tbl[i], 1, 1, 0, 0, 0, 8'h00));
            check(r.rdata, tbl[i] ^ 8'h5c);
        end
        go(mk(8'hff, 1, 1, 0, 0, 0, 8'h00));
        check({r.valid, r.reserved, r.rdata[5:0]}, 8'hc0);
    endtask : t_bytes
    // Bit access allowed at nibble 0 and 8, refused elsewhere.
    task automatic t_bits();
        go(mk(8'h90, 1, 0, 1, 1, 3'h3, 8'h00));
        check(reg_image[16], 8'h08);
        go(mk(8'ha8, 1, 1, 0, 1, 3'h2, 8'h00));
        check({6'h00, r.rbit, r.bit_refused}, 8'h02);
        go(mk(8'h82, 1, 0, 1, 1, 3'h0, 8'h00));
        check({7'h00, r.bit_refused}, 8'h01);
        go(mk(8'h82, 1, 1, 0, 0, 0, 8'h00));
        check(r.rdata, 8'h00);
    endtask : t_bits
    // Lower direct and upper indirect accesses go to ram and get no answer.
    task automatic t_routes();
        go(mk(8'h7f, 1, 1, 0, 0, 0, 8'h00));
        check({6'h00, sel, r.valid}, 8'h02);
        go(mk(8'hb6, 0, 1, 0, 0, 0, 8'h00));
        check({6'h00, sel, r.valid}, 8'h02);
        go(mk(8'h80, 1, 1, 0, 0, 0, 8'h00));
        check({6'h00, sel, r.valid}, 8'h01);
    endtask : t_routes
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // A hang is cut short well past the fifty-odd cycles the run needs.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize();
        end
    end
    // Main sequence.
    initial begin
        err_total = 0;
        n_tests = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        t_after_reset();
        t_bytes();
        t_bits();
        t_routes();
        summarize();
    end
endmodule : sfr_space_decoder_tb
